// ### hw/periph_irq_cfg.svh
// Purpose: Offsets, field positions and reset values of the peripheral
//          interrupt enable block
// Assumes: Byte-wide register port, word index equals printed address
// Notes:   Status and mask offsets are local choices
`ifndef PERIPH_IRQ_CFG_SVH
`define PERIPH_IRQ_CFG_SVH

`define ADDR_W              8
`define OFS_IRQ_ENABLE      8'h8c
`define OFS_CORE_CTRL       8'h8b
`define OFS_EVT_STATUS      8'h90
`define OFS_EVT_MASK        8'h91
`define RST_IRQ_ENABLE      8'h00
`define RST_CORE_CTRL       8'h00
`define RST_EVT_MASK        8'h00
`define BIT_GLOBAL_GATE     6
`define BIT_PARALLEL_PORT   7
`define BIT_ADC_DONE        6
`define BIT_SERIAL_RX       5
`define BIT_SERIAL_TX       4
`define BIT_SYNC_SERIAL     3
`define BIT_CAPCOMP1        2
`define BIT_TIMER2_MATCH    1
`define BIT_TIMER1_OVERFLOW 0
`define SOURCES_SMALL       11
`define SOURCES_LARGE       12

`endif

// ### hw/periph_irq_pkg.sv
// Purpose: Types of the peripheral interrupt enable block
// Assumes: Nothing beyond the cfg header
// Notes:   Byte data throughout
package periph_irq_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic { pkg_small_t_dummy, pkg_large_t_dummy } variant_t;
endpackage : periph_irq_pkg

// ### hw/irq_gate_bank.sv
// Purpose: Per-source gating of peripheral requests
// Assumes: Requests and enables on clk
// Notes:   Registered outputs
`timescale 1ns/10ps
module irq_gate_bank #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] req,
	input  wire logic [WIDTH-1:0] enable,
	input  wire logic             global_gate,
	output logic      [WIDTH-1:0] pass_q
);
	for (genvar i = 0; i < WIDTH; i++) begin : g_src
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				pass_q[i] <= 1'b0;
			end else begin
				// Request passes only with its enable and the gate
				pass_q[i] <= req[i] & enable[i] & global_gate;
			end
		end
	end

	gate_blocks_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!global_gate |=> pass_q == '0)
		else $error("Request passed while global gate low");
	enable_mask_a: assert property (
		@(posedge clk) disable iff (!nrst)
		global_gate |=> pass_q == $past(req & enable))
		else $error("Gated request mismatch");
endmodule : irq_gate_bank

// ### hw/periph_irq_enable.sv
// Purpose: Peripheral interrupt enable register and request gating
// Assumes: Requests synchronous to clk, register port single cycle
// Notes:   Parallel port source exists only when LARGE_VARIANT is 1
`timescale 1ns/10ps
`include "periph_irq_cfg.svh"
module periph_irq_enable import periph_irq_pkg::*; #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input  wire logic               clk,
	input  wire logic               nrst,
	input  wire logic [`ADDR_W-1:0] addr,
	input  wire logic [7:0]         wdata,
	input  wire logic               wr_en,
	input  wire logic               rd_en,
	output logic      [7:0]         rdata_q,
	input  wire logic [7:0]         periph_req,
	output logic      [7:0]         periph_irq_q,
	output logic                    core_irq_q,
	output logic                    irq_q
);
	localparam int SOURCES = LARGE_VARIANT ? `SOURCES_LARGE
		: `SOURCES_SMALL;
	byte_t periph_irq_enable_q;
	byte_t core_irq_control_reg_q;
	byte_t evt_status_q;
	byte_t evt_mask_q;
	byte_t req_present;
	byte_t gated;
	logic  periph_irq_global_gate;
	logic  wr_enable_sel;
	logic  wr_core_sel;
	logic  wr_status_sel;
	logic  wr_mask_sel;

	// Parallel port line tied off on the small variant
	assign req_present = LARGE_VARIANT ? periph_req
		: {1'b0, periph_req[6:0]};
	assign periph_irq_global_gate =
		core_irq_control_reg_q[`BIT_GLOBAL_GATE];

	// Write decode
	assign wr_enable_sel = wr_en && addr == `OFS_IRQ_ENABLE;
	assign wr_core_sel   = wr_en && addr == `OFS_CORE_CTRL;
	assign wr_status_sel = wr_en && addr == `OFS_EVT_STATUS;
	assign wr_mask_sel   = wr_en && addr == `OFS_EVT_MASK;

	// Enable register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			periph_irq_enable_q <= `RST_IRQ_ENABLE;
		end else if (wr_enable_sel) begin
			periph_irq_enable_q <= wdata;
		end
	end

	// Core control register holding the global gate
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			core_irq_control_reg_q <= `RST_CORE_CTRL;
		end else if (wr_core_sel) begin
			core_irq_control_reg_q <= wdata;
		end
	end

	irq_gate_bank #(.WIDTH(8)) u_gate (
		.clk         (clk),
		.nrst        (nrst),
		.req         (req_present),
		.enable      (periph_irq_enable_q),
		.global_gate (periph_irq_global_gate),
		.pass_q      (gated)
	);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			periph_irq_q <= 8'h00;
			core_irq_q   <= 1'b0;
		end else begin
			periph_irq_q <= gated;
			core_irq_q   <= |gated;
		end
	end

	// Sticky event status, set wins over write-one-to-clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			evt_status_q <= 8'h00;
		end else if (wr_status_sel) begin
			evt_status_q <= (evt_status_q & ~wdata) | gated;
		end else begin
			evt_status_q <= evt_status_q | gated;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			evt_mask_q <= `RST_EVT_MASK;
		end else if (wr_mask_sel) begin
			evt_mask_q <= wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(evt_status_q & evt_mask_q);
		end
	end

	// Read port, data in the cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				`OFS_IRQ_ENABLE: rdata_q <= periph_irq_enable_q;
				`OFS_CORE_CTRL:  rdata_q <= core_irq_control_reg_q;
				`OFS_EVT_STATUS: rdata_q <= evt_status_q;
				`OFS_EVT_MASK:   rdata_q <= evt_mask_q;
				default:         rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	// Register port checks
	enable_write_a: assert property (
		@(posedge clk) disable iff (!nrst)
		wr_enable_sel |=> periph_irq_enable_q == $past(wdata))
		else $error("Enable register did not take write");
	enable_hold_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!wr_enable_sel
		|=> periph_irq_enable_q == $past(periph_irq_enable_q))
		else $error("Enable register changed without write");
	enable_read_a: assert property (
		@(posedge clk) disable iff (!nrst)
		rd_en && addr == `OFS_IRQ_ENABLE
		|=> rdata_q == $past(periph_irq_enable_q))
		else $error("Enable register read wrong");
	rdata_idle_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!rd_en |=> rdata_q == 8'h00)
		else $error("Read data outside read cycle");
	ctrl_write_a: assert property (
		@(posedge clk) disable iff (!nrst)
		wr_core_sel
		|=> core_irq_control_reg_q == $past(wdata))
		else $error("Core control did not take write");
	mask_write_a: assert property (
		@(posedge clk) disable iff (!nrst)
		wr_mask_sel |=> evt_mask_q == $past(wdata))
		else $error("Event mask did not take write");

	// Request path checks
	gate_low_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!periph_irq_global_gate |=> ##1 periph_irq_q == 8'h00)
		else $error("Output while gate low");
	core_gate_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!periph_irq_global_gate |=> ##1 !core_irq_q)
		else $error("Core request while gate low");
	source_block_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!periph_irq_enable_q[`BIT_ADC_DONE]
		|=> ##1 !periph_irq_q[`BIT_ADC_DONE])
		else $error("Masked source forwarded");
	parallel_en_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!periph_irq_enable_q[`BIT_PARALLEL_PORT]
		|=> ##1 !periph_irq_q[`BIT_PARALLEL_PORT])
		else $error("Masked parallel request forwarded");
	small_variant_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!LARGE_VARIANT |-> ##2 !periph_irq_q[`BIT_PARALLEL_PORT])
		else $error("Parallel source on small variant");
	forward_req_a: assert property (
		@(posedge clk) disable iff (!nrst)
		periph_irq_global_gate && periph_irq_enable_q[0] && periph_req[0]
		|=> ##1 periph_irq_q[0])
		else $error("Enabled request not forwarded");
	source_count_a: assert property (
		@(posedge clk)
		SOURCES == (LARGE_VARIANT ? 12 : 11))
		else $error("Source count wrong");

	// Event status and interrupt checks
	status_set_a: assert property (
		@(posedge clk) disable iff (!nrst)
		|gated |=> (evt_status_q & $past(gated)) == $past(gated))
		else $error("Event not recorded in status");
	status_clear_a: assert property (
		@(posedge clk) disable iff (!nrst)
		wr_status_sel
		|=> (evt_status_q & $past(wdata & ~gated)) == 8'h00)
		else $error("Status bit not cleared by write");
	status_hold_a: assert property (
		@(posedge clk) disable iff (!nrst)
		!wr_status_sel
		|=> (evt_status_q & $past(evt_status_q)) == $past(evt_status_q))
		else $error("Status bit lost without write");
	irq_level_a: assert property (
		@(posedge clk) disable iff (!nrst)
		|(evt_status_q & evt_mask_q) |=> irq_q)
		else $error("Interrupt output missing");
	irq_low_a: assert property (
		@(posedge clk) disable iff (!nrst)
		(evt_status_q & evt_mask_q) == 8'h00 |=> !irq_q)
		else $error("Interrupt output without unmasked event");

	fwd_c: cover property (@(posedge clk) disable iff (!nrst) |periph_irq_q);
	irq_c: cover property (@(posedge clk) disable iff (!nrst) irq_q);
	gate_c: cover property (@(posedge clk) disable iff (!nrst)
		periph_irq_global_gate && periph_irq_enable_q == 8'hff);
	collide_c: cover property (@(posedge clk) disable iff (!nrst)
		wr_status_sel && |(gated & wdata));
	irq_drop_c: cover property (@(posedge clk) disable iff (!nrst)
		irq_q ##1 !irq_q);
endmodule : periph_irq_enable

// ### sim/periph_irq_enable_tb.sv
// Purpose: Self-checking bench of the peripheral interrupt enable block
// Assumes: Large and small variants side by side, timing as handed over
// Notes:   Random gating trials from a fixed seed among corner cases
`timescale 1ns/10ps
`include "periph_irq_cfg.svh"
module periph_irq_enable_tb;
	logic       clk        = 1'b0;
	logic       nrst       = 1'b0;
	logic [7:0] addr       = 8'h00;
	logic [7:0] wdata      = 8'h00;
	logic [7:0] periph_req = 8'h00;
	logic       wr_en      = 1'b0;
	logic       rd_en      = 1'b0;
	logic [7:0] rdata_q;
	logic [7:0] periph_irq_q;
	logic       core_irq_q;
	logic       irq_q;
	logic [7:0] wdata_small;
	logic [7:0] rdata_small;
	logic [7:0] periph_irq_small;
	logic       core_irq_small;
	logic [7:0] exp_small;
	logic [7:0] en;
	logic [7:0] req;
	logic [7:0] gate_byte;
	int         fail_count = 0;
	int         n_compared = 0;

	always #20 clk = ~clk;

	periph_irq_enable #(.LARGE_VARIANT(1'b1)) i_dut (
		.clk          (clk),
		.nrst         (nrst),
		.addr         (addr),
		.wdata        (wdata),
		.wr_en        (wr_en),
		.rd_en        (rd_en),
		.rdata_q      (rdata_q),
		.periph_req   (periph_req),
		.periph_irq_q (periph_irq_q),
		.core_irq_q   (core_irq_q),
		.irq_q        (irq_q)
	);

	// Small variant; software keeps the parallel port enable clear
	assign wdata_small = {1'b0, wdata[6:0]};

	periph_irq_enable #(.LARGE_VARIANT(1'b0)) i_dut_small (
		.clk          (clk),
		.nrst         (nrst),
		.addr         (addr),
		.wdata        (wdata_small),
		.wr_en        (wr_en),
		.rd_en        (rd_en),
		.rdata_q      (rdata_small),
		.periph_req   (periph_req),
		.periph_irq_q (periph_irq_small),
		.core_irq_q   (core_irq_small),
		.irq_q        ()
	);

	// Expected gated requests
	function automatic logic [7:0] gated(input logic [7:0] e, r, g);
		return g[`BIT_GLOBAL_GATE] ? (e & r) : 8'h00;
	endfunction : gated

	task automatic chk(input string what, input logic [7:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	task automatic rdc(input string what, input logic [7:0] a, exp);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 chk(what, exp, rdata_q);
	endtask : rdc

	task automatic settle;
		repeat (4) @(posedge clk);
		#1;
	endtask : settle

	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	initial begin
		void'($urandom(44));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rdc("enable reset", `OFS_IRQ_ENABLE, `RST_IRQ_ENABLE);
		rdc("unmapped", 8'h8d, 8'h00);
		wr(`OFS_IRQ_ENABLE, 8'ha5);
		rdc("enable", `OFS_IRQ_ENABLE, 8'ha5);
		chk("small enable", 8'h25, rdata_small);
		wr(`OFS_IRQ_ENABLE, 8'h5a);
		rdc("enable", `OFS_IRQ_ENABLE, 8'h5a);
		wr(`OFS_IRQ_ENABLE, 8'hff);
		periph_req <= 8'hff;
		settle();
		chk("gate low", 8'h00, periph_irq_q);
		wr(`OFS_CORE_CTRL, 8'h40);
		for (int i = 0; i < 8; i++) begin
			wr(`OFS_IRQ_ENABLE, 8'h01 << i);
			settle();
			chk("one source", 8'h01 << i, periph_irq_q);
			chk("core irq", 8'h01, {7'h00, core_irq_q});
			chk("small one", 8'h7f & (8'h01 << i), periph_irq_small);
		end
		repeat (24) begin
			en        = 8'($urandom);
			req       = 8'($urandom);
			gate_byte = {1'b0, 1'($urandom), 6'h00};
			exp_small = gated(en & 8'h7f, req, gate_byte);
			wr(`OFS_IRQ_ENABLE, en);
			wr(`OFS_CORE_CTRL, gate_byte);
			periph_req <= req;
			settle();
			chk("gated", gated(en, req, gate_byte), periph_irq_q);
			chk("core irq", {7'h00, |gated(en, req, gate_byte)},
				{7'h00, core_irq_q});
			chk("small gated", exp_small, periph_irq_small);
			chk("small core", {7'h00, |exp_small}, {7'h00, core_irq_small});
		end
		@(posedge clk);
		periph_req <= 8'h00;
		settle();
		wr(`OFS_EVT_STATUS, 8'hff);
		rdc("status clear", `OFS_EVT_STATUS, 8'h00);
		wr(`OFS_EVT_MASK, 8'h00);
		wr(`OFS_CORE_CTRL, 8'h40);
		wr(`OFS_IRQ_ENABLE, 8'h01);
		periph_req <= 8'h03;
		settle();
		@(posedge clk);
		periph_req <= 8'h00;
		settle();
		rdc("status sticky", `OFS_EVT_STATUS, 8'h01);
		chk("irq masked", 8'h00, {7'h00, irq_q});
		wr(`OFS_EVT_MASK, 8'h01);
		rdc("mask", `OFS_EVT_MASK, 8'h01);
		settle();
		chk("irq unmasked", 8'h01, {7'h00, irq_q});
		wr(`OFS_EVT_STATUS, 8'h01);
		settle();
		chk("irq cleared", 8'h00, {7'h00, irq_q});
		rdc("status w1c", `OFS_EVT_STATUS, 8'h00);
		@(posedge clk);
		periph_req <= 8'h01;
		settle();
		wr(`OFS_EVT_STATUS, 8'h01);
		rdc("status set wins", `OFS_EVT_STATUS, 8'h01);
		chk("irq set wins", 8'h01, {7'h00, irq_q});
		@(posedge clk);
		periph_req <= 8'h00;
		nrst       <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rdc("enable reset", `OFS_IRQ_ENABLE, `RST_IRQ_ENABLE);
		chk("irq reset", 8'h00, {7'h00, irq_q});
		give_verdict();
	end
endmodule : periph_irq_enable_tb
